/* ddsl_pkg.sv */
package ddsl_pkg;
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam logic [4:0] LAST_EDGE = 5'h10;
    // upper nibble layout of the received word
    localparam int CH_POS = 15;
    localparam int MODE_HI = 14;
    localparam int MODE_LO = 13;
    localparam int PD_POS = 12;
    localparam logic [1:0] MODE_WRITE_ONE = 2'h0;
    localparam logic [1:0] MODE_WRITE_BOTH = 2'h1;
    localparam logic [1:0] MODE_PD_1K = 2'h2;
    localparam logic [1:0] MODE_PD_100K = 2'h3;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [1:0] TERM_RESET = 2'h0;
    localparam int SCLK_MAX_MHZ = 40;

    typedef enum logic [1:0] {
        TERM_DRIVE,
        TERM_1K,
        TERM_100K,
        TERM_HIGHZ
    } ddsl_term_t;

    typedef struct packed {
        logic [11:0] code;
        ddsl_term_t term;
    } ddsl_chan_t;

    typedef struct packed {
        logic channel_b;
        logic [1:0] mode;
        logic power_down;
        logic [11:0] value;
    } ddsl_word_t;
endpackage

/* ddsl_sync.sv */
module ddsl_sync (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic async_in,
    input wire logic reset_value_in,
    output logic sync_out
);
    logic meta_q;
    logic sync_q;
    logic meta_d;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // reset always loads ones; reset_value_in does not reach the flops
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = reset_value_in ? sync_q : sync_q;
endmodule

/* ddsl_load_ctrl.sv */
// What this block does
// - keep a sixteen bit shift register holding channel, mode, power-down, value
// - two-bit mode field updates one channel or both together
// - after reset both outputs read zero until a valid write
// - while sync is low, sample data on each of the first sixteen falling serial clocks
// - host lowers sync to start; shifting enabled only while sync low
// - apply the received word on the sixteenth falling clock edge
// - sync rising before edge sixteen discards the partial frame
// - power-down state with three selectable output terminations
module ddsl_load_ctrl (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic sclk_in,
    input wire logic sync_n_in,
    input wire logic din_in,
    output ddsl_pkg::ddsl_chan_t channel_a_output_out,
    output ddsl_pkg::ddsl_chan_t channel_b_output_out,
    output logic update_out,
    output logic abort_out
);
    import ddsl_pkg::*;

    logic sclk_s;
    logic sync_n_s;
    logic din_s;

    // pins cross from the host clock domain through two flops
    ddsl_sync u_sclk (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .async_in(sclk_in),
        .reset_value_in(1'b1),
        .sync_out(sclk_s)
    );
    ddsl_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .async_in(sync_n_in),
        .reset_value_in(1'b1),
        .sync_out(sync_n_s)
    );
    ddsl_sync u_din (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .async_in(din_in),
        .reset_value_in(1'b1),
        .sync_out(din_s)
    );

    logic sclk_prev_q, sclk_prev_d;
    logic [15:0] shift_q, shift_d;
    logic [4:0] count_q, count_d;
    logic done_q, done_d;
    logic in_frame_q, in_frame_d;
    ddsl_chan_t chan_a_q, chan_a_d;
    ddsl_chan_t chan_b_q, chan_b_d;
    logic update_q, update_d;
    logic abort_q, abort_d;
    logic fall;
    ddsl_word_t word;
    ddsl_term_t pd_term;

    // only sclk_at 25 MHz sampling sees edges: the host must run it well
    // below the pin limit for this core to resolve every edge
    always_comb begin
        fall = sclk_prev_q & ~sclk_s;
        sclk_prev_d = sclk_s;
        shift_d = shift_q;
        count_d = count_q;
        done_d = done_q;
        in_frame_d = in_frame_q;
        chan_a_d = chan_a_q;
        chan_b_d = chan_b_q;
        update_d = 1'b0;
        abort_d = 1'b0;
        word = ddsl_word_t'(shift_q);
        pd_term = TERM_DRIVE;
        if (sync_n_s) begin
            // sync rise before the last edge throws the frame away
            abort_d = in_frame_q & ~done_q;
            count_d = 5'h00;
            done_d = 1'b0;
            in_frame_d = 1'b0;
        end else begin
            in_frame_d = 1'b1;
            if (fall && !done_q) begin
                shift_d = {shift_q[14:0], din_s};
                count_d = count_q + 5'h01;
                if (count_q + 5'h01 == LAST_EDGE) begin
                    done_d = 1'b1;
                    update_d = 1'b1;
                    word = ddsl_word_t'({shift_q[14:0], din_s});
                    unique case (word.mode)
                        MODE_PD_1K: pd_term = TERM_1K;
                        MODE_PD_100K: pd_term = TERM_100K;
                        default: pd_term = TERM_HIGHZ;
                    endcase
                    if (word.power_down) begin
                        // power-down touches both outputs, codes kept
                        chan_a_d.term = pd_term;
                        chan_b_d.term = pd_term;
                    end else if (word.mode == MODE_WRITE_BOTH) begin
                        chan_a_d = '{code: word.value, term: TERM_DRIVE};
                        chan_b_d = '{code: word.value, term: TERM_DRIVE};
                    end else if (word.mode == MODE_WRITE_ONE) begin
                        if (word.channel_b) begin
                            chan_b_d = '{code: word.value, term: TERM_DRIVE};
                        end else begin
                            chan_a_d = '{code: word.value, term: TERM_DRIVE};
                        end
                    end else begin
                        chan_a_d.term = pd_term;
                        chan_b_d.term = pd_term;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_prev_q <= 1'b1;
            shift_q <= 16'h0000;
            count_q <= 5'h00;
            done_q <= 1'b0;
            in_frame_q <= 1'b0;
            chan_a_q <= '{code: CODE_RESET, term: TERM_DRIVE};
            chan_b_q <= '{code: CODE_RESET, term: TERM_DRIVE};
            update_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_prev_d;
            shift_q <= shift_d;
            count_q <= count_d;
            done_q <= done_d;
            in_frame_q <= in_frame_d;
            chan_a_q <= chan_a_d;
            chan_b_q <= chan_b_d;
            update_q <= update_d;
            abort_q <= abort_d;
        end
    end

    assign channel_a_output_out = chan_a_q;
    assign channel_b_output_out = chan_b_q;
    assign update_out = update_q;
    assign abort_out = abort_q;
endmodule

/* ddsl_load_ctrl_checker.sv */
module ddsl_load_ctrl_checker (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic sync_n_in,
    input wire ddsl_pkg::ddsl_chan_t channel_a_output_out,
    input wire ddsl_pkg::ddsl_chan_t channel_b_output_out,
    input wire logic update_out,
    input wire logic abort_out
);
    // both channels as one word, so one check covers both
    wire logic [27:0] outs = {channel_a_output_out, channel_b_output_out};
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    sequence idle_s;
        sync_n_in [*8];
    endsequence
    rst_zero_a: assert property (disable iff (1'h0)
        reset_in |-> !outs && !update_out) else $error("reset value");
    pulse_excl_a: assert property (!(update_out && abort_out))
        else $error("update with abort");
    upd_pulse_a: assert property (update_out |=> !update_out)
        else $error("long update");
    abt_pulse_a: assert property (abort_out |=> !abort_out)
        else $error("long abort");
    out_hold_a: assert property ($changed(outs) |-> update_out)
        else $error("output moved");
    abort_keep_a: assert property (abort_out |-> $stable(outs))
        else $error("abort moved output");
    idle_quiet_a: assert property (
        idle_s |-> !update_out && !abort_out) else $error("busy idle");
    full_done_a: assert property (update_out |=> !abort_out [*5])
        else $error("abort after full frame");
endmodule

/* ddsl_host_model.sv */
module ddsl_host_model (
    input wire logic clk_sys_in,
    output logic sclk_out = 1'h1,
    output logic sync_n_out = 1'h1,
    output logic din_out = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic send(input logic [15:0] w, input int n);
        sync_n_out <= 1'h0;
        for (int i = 0; i < n; i++) begin
            din_out <= w[15-i];
            repeat (4) @(posedge clk_sys_in);
            sclk_out <= 1'h0;
            repeat (4) @(posedge clk_sys_in);
            sclk_out <= 1'h1;
        end
        repeat (4) @(posedge clk_sys_in);
        sync_n_out <= 1'h1;
        din_out <= ~din_out; // released line keeps no value
        repeat (8) @(posedge clk_sys_in);
    endtask
endmodule

/* ddsl_load_ctrl_tb.sv */
module ddsl_load_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ddsl_pkg::*;
    logic clk_sys_in = 1'h0;
    logic reset_in = 1'h0;
    logic sclk_in, sync_n_in, din_in, update_out, abort_out;
    ddsl_chan_t channel_a_output_out, channel_b_output_out;
    ddsl_chan_t exp_a = '0, exp_b = '0;
    ddsl_term_t t;
    int error_cnt = 0, check_count = 0, upd_n = 0, abt_n = 0, u0, a0, n;
    integer seed = 32'h249b;
    logic [15:0] w;
    initial forever #20 clk_sys_in = ~clk_sys_in;
    ddsl_host_model u_ddsl_host_model (.clk_sys_in, .sclk_out(sclk_in),
        .sync_n_out(sync_n_in), .din_out(din_in));
    ddsl_load_ctrl u_ddsl_load_ctrl (.clk_sys_in, .reset_in, .sclk_in,
        .sync_n_in, .din_in, .channel_a_output_out, .channel_b_output_out,
        .update_out, .abort_out);
    always @(posedge clk_sys_in) begin
        upd_n <= upd_n + int'(update_out === 1'h1);
        abt_n <= abt_n + int'(abort_out === 1'h1);
    end
    task automatic chk(input string nm, input logic [13:0] s, e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        // a real edge at time zero, so the async reset acts before any clock
        reset_in <= 1'h1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'h0;
        repeat (3) @(posedge clk_sys_in);
        chk("init", channel_b_output_out, 14'h0);
        for (int i = 0; i < 20; i++) begin
            w = 16'($random(seed));
            w[14:13] = 2'(i);
            // every fifth frame cut short, the first with no edge at all
            n = (i % 5 == 4) ? (i * 4) % 16 : 16;
            u0 = upd_n;
            a0 = abt_n;
            u_ddsl_host_model.send(w, n);
            t = w[14] ? ddsl_term_t'(w[14:13] - 2'h1) : TERM_HIGHZ;
            if (n == 16 && (w[14] || w[12])) begin
                {exp_a.term, exp_b.term} = {t, t};
            end else if (n == 16) begin
                if (!w[15] || w[13]) exp_a = {w[11:0], TERM_DRIVE};
                if (w[15] || w[13]) exp_b = {w[11:0], TERM_DRIVE};
            end
            chk("upd", 14'(upd_n - u0), 14'(n == 16));
            chk("abt", 14'(abt_n - a0), 14'(n < 16));
            chk("a", channel_a_output_out, exp_a);
            chk("b", channel_b_output_out, exp_b);
        end
        reset_in <= 1'h1;
        @(posedge clk_sys_in);
        chk("rst", channel_a_output_out, 14'h0);
        end_sim();
    end
endmodule
bind ddsl_load_ctrl ddsl_load_ctrl_checker u_ddsl_load_ctrl_checker (
    .clk_sys_in, .reset_in, .sync_n_in, .channel_a_output_out,
    .channel_b_output_out, .update_out, .abort_out);
